// ==== rtl/mrr_bank.sv ====
// measurement result register bank with current gain trim
//
// Operation
// - aux low byte read-only, resets zero
// - 8-bit temperature code, 92 + 3/4 code
// - alarm bit 0 shows over-temperature
// - alarm bit 1 shows under-voltage
// - alarm bit 2 shows over-current
// - read-only revision byte, fixed upper nibble
// - raw result bits 11:8 in high bits 3:0
// - raw result bits 7:0 in low byte
// - high bit 5 is inverse of alert pin
// - high bit 6 set on any warning
// - current scaled by (1024 + trim)/1024
`timescale 1ns/100ps
module mrr_bank #(
  parameter logic [7:0] ID_CODE = mrr_pkg::ID_CODE_DEF,
  parameter logic [3:0] REV_LO  = mrr_pkg::REV_LO_DEF
) (
  input  wire logic                         clock,
  input  wire logic                         reset_n,
  input  wire mrr_pkg::mrr_req_t            req,
  output logic      [mrr_pkg::DW-1:0]       rdata,
  output logic                              rvalid,
  input  wire mrr_pkg::mrr_sample_t         sample,
  input  wire mrr_pkg::mrr_alarm_t          alarm,
  input  wire logic                         alert_output_n,
  input  wire logic [mrr_pkg::RW-1:0]       current_in,
  output logic      [mrr_pkg::RW-1:0]       current_out,
  output logic      [mrr_pkg::DW-1:0]       current_gain_trim
);
  localparam int DW = mrr_pkg::DW;
  localparam int RW = mrr_pkg::RW;

  // ---------------------------------------------------------------------
  // sample capture
  // ---------------------------------------------------------------------
  // raw, aux and temp latched on one valid strobe so high/low always pair; alarm and pending are registered every cycle
  logic [RW-1:0] raw_r, raw_nxt;
  logic [RW-1:0] aux_r, aux_nxt;
  logic [DW-1:0] temp_r, temp_nxt;
  mrr_pkg::mrr_alarm_t alarm_r, alarm_nxt;
  logic          pend_r, pend_nxt;

  always_comb begin
    raw_nxt   = raw_r;
    aux_nxt   = aux_r;
    temp_nxt  = temp_r;
    alarm_nxt = alarm;
    pend_nxt  = ~alert_output_n;
    if (sample.valid) begin
      raw_nxt  = sample.raw;
      aux_nxt  = sample.aux;
      temp_nxt = sample.temp;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      raw_r   <= mrr_pkg::RST_RESULT;
      aux_r   <= mrr_pkg::RST_RESULT;
      temp_r  <= mrr_pkg::RST_BYTE;
      alarm_r <= '0;
      pend_r  <= 1'b0;
    end else begin
      raw_r   <= raw_nxt;
      aux_r   <= aux_nxt;
      temp_r  <= temp_nxt;
      alarm_r <= alarm_nxt;
      pend_r  <= pend_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // trim register and gain stage
  // ---------------------------------------------------------------------
  logic [DW-1:0] trim_nxt;

  always_comb begin
    trim_nxt = current_gain_trim;
    if (req.wr && req.addr == mrr_pkg::OFS_CUR_TRIM) begin
      trim_nxt = req.wdata;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      current_gain_trim <= mrr_pkg::RST_TRIM;
    end else begin
      current_gain_trim <= trim_nxt;
    end
  end

  mrr_gain #(.W(RW)) u_gain (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_value  (current_in),
    .trim      (current_gain_trim),
    .out_value (current_out)
  );

  // ---------------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------------
  function automatic logic [DW-1:0] high_byte(
    input logic [RW-1:0] v,
    input logic          pend,
    input logic          warn
  );
    logic [DW-1:0] b;
    b = '0;
    b[3:0] = v[RW-1:DW];
    b[mrr_pkg::BIT_INT_PEND] = pend;
    b[mrr_pkg::BIT_WARN]     = warn;
    return b;
  endfunction : high_byte

  logic          warn;
  logic [DW-1:0] alarm_byte;
  logic [DW-1:0] rdata_nxt;
  logic          rvalid_nxt;

  always_comb begin
    warn = alarm_r.over_temp | alarm_r.under_volt | alarm_r.over_curr;
    alarm_byte = '0;
    alarm_byte[mrr_pkg::BIT_OVER_TEMP]  = alarm_r.over_temp;
    alarm_byte[mrr_pkg::BIT_UNDER_VOLT] = alarm_r.under_volt;
    alarm_byte[mrr_pkg::BIT_OVER_CURR]  = alarm_r.over_curr;
    rvalid_nxt = req.rd;
    rdata_nxt  = '0;
    if (req.rd) begin
      unique case (req.addr)
        mrr_pkg::OFS_AUX_LO:   rdata_nxt = aux_r[DW-1:0];
        mrr_pkg::OFS_TEMP:     rdata_nxt = temp_r;
        mrr_pkg::OFS_ALARM:    rdata_nxt = alarm_byte;
        mrr_pkg::OFS_CHIP_ID:  rdata_nxt = ID_CODE;
        mrr_pkg::OFS_REV:      rdata_nxt = {mrr_pkg::REV_HI_DEF, REV_LO};
        mrr_pkg::OFS_RAW_HI:   rdata_nxt = high_byte(raw_r, pend_r, warn);
        mrr_pkg::OFS_RAW_LO:   rdata_nxt = raw_r[DW-1:0];
        mrr_pkg::OFS_CUR_TRIM: rdata_nxt = current_gain_trim;
        default:               rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata  <= mrr_pkg::RST_BYTE;
      rvalid <= 1'b0;
    end else begin
      rdata  <= rdata_nxt;
      rvalid <= rvalid_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  sequence rd_at(logic [5:0] a);
    req.rd && req.addr == a;
  endsequence

  AST_AUX_LO: assert property (@(posedge clock) disable iff (!reset_n)
    rd_at(mrr_pkg::OFS_AUX_LO) |=> rdata == $past(aux_r[7:0]))
    else $error("aux low byte mismatch");
  AST_TEMP: assert property (@(posedge clock) disable iff (!reset_n)
    rd_at(mrr_pkg::OFS_TEMP) |=> rdata == $past(temp_r))
    else $error("temperature byte mismatch");
  AST_OT: assert property (@(posedge clock) disable iff (!reset_n)
    alarm.over_temp ##1 rd_at(mrr_pkg::OFS_ALARM) |=> rdata[0])
    else $error("over-temperature bit missing");
  AST_UV: assert property (@(posedge clock) disable iff (!reset_n)
    alarm.under_volt ##1 rd_at(mrr_pkg::OFS_ALARM) |=> rdata[1])
    else $error("under-voltage bit missing");
  AST_OC: assert property (@(posedge clock) disable iff (!reset_n)
    alarm.over_curr ##1 rd_at(mrr_pkg::OFS_ALARM) |=> rdata[2])
    else $error("over-current bit missing");
  AST_REV: assert property (@(posedge clock) disable iff (!reset_n)
    rd_at(mrr_pkg::OFS_REV) |=> rdata[7:4] == mrr_pkg::REV_HI_DEF)
    else $error("revision nibble wrong");
  AST_RAW_HI: assert property (@(posedge clock) disable iff (!reset_n)
    sample.valid ##1 rd_at(mrr_pkg::OFS_RAW_HI)
    |=> rdata[3:0] == $past(sample.raw[11:8], 2))
    else $error("raw high nibble mismatch");
  AST_RAW_LO: assert property (@(posedge clock) disable iff (!reset_n)
    sample.valid ##1 rd_at(mrr_pkg::OFS_RAW_LO)
    |=> rdata == $past(sample.raw[7:0], 2))
    else $error("raw low byte mismatch");
  AST_PEND: assert property (@(posedge clock) disable iff (!reset_n)
    !alert_output_n ##1 rd_at(mrr_pkg::OFS_RAW_HI) |=> rdata[5])
    else $error("pending bit not set");
  AST_WARN: assert property (@(posedge clock) disable iff (!reset_n)
    rd_at(mrr_pkg::OFS_RAW_HI) |=> rdata[6] == $past(warn))
    else $error("warning bit mismatch");
  AST_TRIM: assert property (@(posedge clock) disable iff (!reset_n)
    req.wr && req.addr == mrr_pkg::OFS_CUR_TRIM
    |=> current_gain_trim == $past(req.wdata))
    else $error("trim write lost");
  AST_UNUSED: assert property (@(posedge clock) disable iff (!reset_n)
    rd_at(mrr_pkg::OFS_RAW_HI) |=> rdata[7] == 1'b0 && rdata[4] == 1'b0)
    else $error("unused bits not zero");
  AST_HOLD: assert property (@(posedge clock) disable iff (!reset_n)
    !sample.valid |=> raw_r == $past(raw_r))
    else $error("result changed without sample");
endmodule : mrr_bank

// ==== rtl/mrr_gain.sv ====
// current gain correction: out = in * (1024 + trim) / 1024, saturated
`timescale 1ns/100ps
module mrr_gain #(
  parameter int W = 12
) (
  input  wire logic                clock,
  input  wire logic                reset_n,
  input  wire logic [W-1:0]        in_value,
  input  wire logic [7:0]          trim,
  output logic      [W-1:0]        out_value
);
  localparam int PW = W + mrr_pkg::GAIN_SHIFT + 2;
  localparam logic signed [W-1:0] MAXV = {1'b0, {(W-1){1'b1}}};
  localparam logic signed [W-1:0] MINV = {1'b1, {(W-1){1'b0}}};

  logic signed [PW-1:0] factor;
  logic signed [PW-1:0] prod;
  logic signed [PW-1:0] scaled;
  logic        [W-1:0]  out_nxt;

  always_comb begin
    factor = $signed(mrr_pkg::GAIN_UNITY) +
             PW'($signed({{(PW-8){trim[7]}}, trim}));
    prod   = PW'($signed({{(PW-W){in_value[W-1]}}, in_value}) * factor);
    scaled = prod >>> mrr_pkg::GAIN_SHIFT;
    // saturate rather than wrap so a large trim cannot flip the sign
    if (scaled > PW'(MAXV)) begin
      out_nxt = MAXV;
    end else if (scaled < PW'(MINV)) begin
      out_nxt = MINV;
    end else begin
      out_nxt = scaled[W-1:0];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      out_value <= mrr_pkg::RST_RESULT;
    end else begin
      out_value <= out_nxt;
    end
  end
endmodule : mrr_gain

// ==== rtl/mrr_pkg.sv ====
// package: register map, field layout and carriers for the result bank
package mrr_pkg;
  localparam int DW = 8;
  localparam int RW = 12;
  localparam int AW = 6;

  localparam logic [AW-1:0] OFS_AUX_LO   = 6'h15;
  localparam logic [AW-1:0] OFS_TEMP     = 6'h16;
  localparam logic [AW-1:0] OFS_ALARM    = 6'h17;
  localparam logic [AW-1:0] OFS_CHIP_ID  = 6'h18;
  localparam logic [AW-1:0] OFS_REV      = 6'h19;
  localparam logic [AW-1:0] OFS_RAW_HI   = 6'h1A;
  localparam logic [AW-1:0] OFS_RAW_LO   = 6'h1B;
  localparam logic [AW-1:0] OFS_CUR_TRIM = 6'h3A;

  localparam int BIT_OVER_TEMP  = 0;
  localparam int BIT_UNDER_VOLT = 1;
  localparam int BIT_OVER_CURR  = 2;
  localparam int BIT_INT_PEND   = 5;
  localparam int BIT_WARN       = 6;

  localparam logic [DW-1:0] RST_BYTE    = 8'h00;
  localparam logic [RW-1:0] RST_RESULT  = 12'h000;
  localparam logic [DW-1:0] RST_TRIM    = 8'h00;
  // gain factor is (UNITY + trim) / UNITY, UNITY = 2**GAIN_SHIFT
  localparam int            GAIN_SHIFT  = 10;
  localparam logic [RW+GAIN_SHIFT+1:0] GAIN_UNITY = 24'h000400;

  // arbitrary neutral identity values, not tied to any real part
  localparam logic [DW-1:0] ID_CODE_DEF = 8'hA5;
  localparam logic [3:0]    REV_HI_DEF  = 4'hC;
  localparam logic [3:0]    REV_LO_DEF  = 4'h0;

  typedef struct packed {
    logic          valid;
    logic [RW-1:0] raw;
    logic [RW-1:0] aux;
    logic [DW-1:0] temp;
  } mrr_sample_t;

  typedef struct packed {
    logic over_temp;
    logic under_volt;
    logic over_curr;
  } mrr_alarm_t;

  typedef struct packed {
    logic          rd;
    logic          wr;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } mrr_req_t;
endpackage : mrr_pkg

// ==== testbench/mrr_bank_tb_top.sv ====
// self-checking bench for the result register bank
`timescale 1ns/100ps
module mrr_bank_tb_top;
  logic                 clock = 1'b0;
  logic                 reset_n = 1'b0;
  mrr_pkg::mrr_req_t    req;
  mrr_pkg::mrr_sample_t sample = '0;
  mrr_pkg::mrr_alarm_t  alarm = '0;
  logic                 alert_output_n = 1'b1;
  logic [11:0]          current_in = '0;
  logic [11:0]          current_out;
  logic [7:0]           rdata;
  logic [7:0]           current_gain_trim;
  logic                 rvalid;
  logic [7:0]           exp_q[$];
  int                   n_fail = 0;
  int                   checks_done = 0;
  int                   cyc = 0;

  always #12.5 clock = ~clock;

  mrr_host_model host_u (.clock(clock), .req(req));
  mrr_bank dut_u (.clock(clock), .reset_n(reset_n), .req(req),
    .rdata(rdata), .rvalid(rvalid), .sample(sample), .alarm(alarm),
    .alert_output_n(alert_output_n), .current_in(current_in),
    .current_out(current_out), .current_gain_trim(current_gain_trim));

  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic end_sim();
    if (n_fail == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // a read answer with no pending note is a mismatch by itself
  always @(negedge clock) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) cmp({4'h0, rdata}, 12'hFFF);
      else cmp({4'h0, rdata}, {4'h0, exp_q.pop_front()});
    end
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.issue(1'b1, 1'b0, a, 8'h00);
  endtask : rd

  function automatic logic [11:0] scale(input logic [11:0] c,
                                        input logic [7:0] t);
    int p;
    p = ($signed(c) * (1024 + $signed(t))) / 1024;
    if (p > 2047) p = 2047;
    if (p < -2048) p = -2048;
    return p[11:0];
  endfunction : scale

  // operands chosen as exact multiples so rounding cannot matter
  task automatic gain(input logic [11:0] c, input logic [7:0] t);
    current_in = c;
    host_u.issue(1'b0, 1'b1, mrr_pkg::OFS_CUR_TRIM, t);
    host_u.issue(1'b0, 1'b0, 6'h00, 8'h00);
    repeat (3) @(posedge clock);
    #2;
    cmp({4'h0, current_gain_trim}, {4'h0, t});
    cmp(current_out, scale(c, t));
  endtask : gain

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [11:0] r;
    logic [11:0] a;
    logic [7:0]  tc;
    logic [2:0]  al;
    logic        pend;
    logic [5:0]  zero_ofs[6];
    zero_ofs = '{6'h15, 6'h16, 6'h17, 6'h1A, 6'h1B, 6'h3A};
    void'($urandom(32'h80C0));
    repeat (4) @(posedge clock);
    #2;
    reset_n = 1'b1;
    foreach (zero_ofs[i]) rd(zero_ofs[i], 8'h00);
    rd(mrr_pkg::OFS_CHIP_ID, mrr_pkg::ID_CODE_DEF);
    rd(mrr_pkg::OFS_REV, {mrr_pkg::REV_HI_DEF, mrr_pkg::REV_LO_DEF});
    rd(6'h20, 8'h00);
    host_u.issue(1'b0, 1'b1, mrr_pkg::OFS_AUX_LO, 8'hFF);
    host_u.issue(1'b0, 1'b1, mrr_pkg::OFS_RAW_HI, 8'hFF);
    rd(mrr_pkg::OFS_AUX_LO, 8'h00);
    rd(mrr_pkg::OFS_RAW_HI, 8'h00);
    repeat (6) begin
      r = $urandom();
      a = $urandom();
      tc = $urandom();
      al = $urandom();
      pend = $urandom();
      sample = '{valid: 1'b1, raw: r, aux: a, temp: tc};
      alarm = al;
      alert_output_n = ~pend;
      host_u.issue(1'b0, 1'b0, 6'h00, 8'h00);
      sample.valid = 1'b0;
      sample.raw = ~r;
      sample.aux = ~a;
      host_u.issue(1'b0, 1'b0, 6'h00, 8'h00);
      rd(mrr_pkg::OFS_RAW_HI, {1'b0, |al, pend, 1'b0, r[11:8]});
      rd(mrr_pkg::OFS_RAW_LO, r[7:0]);
      rd(mrr_pkg::OFS_AUX_LO, a[7:0]);
      rd(mrr_pkg::OFS_TEMP, tc);
      rd(mrr_pkg::OFS_ALARM, {5'h00, al[0], al[1], al[2]});
    end
    host_u.issue(1'b0, 1'b0, 6'h00, 8'h00);
    gain(12'h040, 8'h10);
    gain(12'hFC0, 8'hF0);
    gain(12'h7C0, 8'h70);
    gain(12'h800, 8'h80);
    repeat (4) gain(12'(($urandom() % 64) * 64), 8'(($urandom() % 16) * 16));
    rd(mrr_pkg::OFS_CUR_TRIM, current_gain_trim);
    host_u.issue(1'b0, 1'b0, 6'h00, 8'h00);
    repeat (3) @(posedge clock);
    end_sim();
  end
endmodule : mrr_bank_tb_top

// ==== testbench/mrr_host_model.sv ====
// host-side model issuing register requests to the bank
`timescale 1ns/100ps
module mrr_host_model (
  input  wire logic        clock,
  output mrr_pkg::mrr_req_t req
);
  initial req = '0;
  // called 2 ns after an edge; fields hold through the next edge
  task automatic issue(input logic rd, input logic wr,
                       input logic [5:0] addr, input logic [7:0] data);
    req = '{rd: rd, wr: wr, addr: addr, wdata: data};
    @(posedge clock);
    #2;
  endtask : issue
endmodule : mrr_host_model
